// >>> verilog/spi_status_irq.sv
// serial channel status flags, register map and interrupt request
`timescale 1ns/1ns
`default_nettype none
module spi_status_irq (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    input  wire logic        i_rx_load,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic        i_tx_load,
    input  wire logic        i_xfer_start,
    input  wire logic        i_xfer_done,
    input  wire logic        i_slave_select_in_n,
    input  wire logic        i_global_irq_allow_bit,
    input  wire logic [2:0]  i_current_priority_field,
    input  wire logic        i_higher_pending,
    output logic      [7:0]  o_tx_byte,
    output logic             o_chan_enable,
    output logic             o_master_mode,
    output logic             o_clk_polarity,
    output logic             o_clk_phase,
    output logic             o_irq_pulse,
    output logic             o_core_irq_req,
    output logic             o_irq_accept,
    output logic      [7:0]  o_vector_num,
    output logic      [7:0]  o_vector_offset
);
    typedef struct packed {
        logic        rx_full_irq_enable;
        logic        tx_empty_irq_enable;
        logic        phase;
        logic        polarity;
        logic        master;
        logic        enable;
        logic [7:0]  tx_buf;
        logic [7:0]  rx_buf;
        logic        rx_buffer_full_flag;
        logic        tx_buffer_empty_flag;
        logic        busy_or_selected_flag;
        logic [15:0] rdata;
    } chan_t;

    chan_t c_q;
    chan_t c_d;

    // ========================================
    // address decode
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] r);
        hit = (a == r);
    endfunction

    logic wr_tx;
    logic wr_ctl;
    logic rd_rx;
    logic wr_iflg;
    logic wr_ien;
    logic wr_ilv;
    logic rx_irq;
    logic tx_irq;

    assign wr_tx   = i_wr && hit(i_addr, spi_irq_pkg::TXD_ADDR);
    assign wr_ctl  = i_wr && hit(i_addr, spi_irq_pkg::CTL_ADDR);
    assign rd_rx   = i_rd && hit(i_addr, spi_irq_pkg::RXD_ADDR);
    assign wr_iflg = i_wr && hit(i_addr, spi_irq_pkg::IFLG_ADDR);
    assign wr_ien  = i_wr && hit(i_addr, spi_irq_pkg::IEN_ADDR);
    assign wr_ilv  = i_wr && hit(i_addr, spi_irq_pkg::ILV3_ADDR);

    // ========================================
    // interrupt request
    // rx cause gated by its enable
    assign rx_irq = i_rx_load && c_q.rx_full_irq_enable;
    // tx cause gated by its enable
    assign tx_irq = i_tx_load && c_q.tx_empty_irq_enable;
    assign o_irq_pulse = rx_irq || tx_irq;

    logic        ctrl_pending;
    logic        ctrl_fwd_en;
    logic [2:0]  ctrl_level;
    logic [15:0] st_word;

    always_comb begin
        st_word = 16'h0000;
        st_word[spi_irq_pkg::ST_BSY_BIT] = c_q.busy_or_selected_flag;
        st_word[spi_irq_pkg::ST_RXF_BIT] = c_q.rx_buffer_full_flag;
        st_word[spi_irq_pkg::ST_TXE_BIT] = c_q.tx_buffer_empty_flag;
    end

    // ========================================
    // next state
    always_comb begin
        c_d = c_q;
        if (c_q.master) begin
            if (i_xfer_done) begin
                c_d.busy_or_selected_flag = 1'b0;
            end
            if (i_xfer_start) begin
                c_d.busy_or_selected_flag = 1'b1;
            end
        end else begin
            c_d.busy_or_selected_flag = !i_slave_select_in_n;
        end
        if (rd_rx) begin
            c_d.rx_buffer_full_flag = 1'b0;
        end
        if (i_rx_load) begin
            c_d.rx_buffer_full_flag = 1'b1;
            c_d.rx_buf = i_rx_byte;
        end
        if (wr_tx) begin
            c_d.tx_buffer_empty_flag = 1'b0;
            c_d.tx_buf = i_wdata[7:0];
        end
        if (i_tx_load) begin
            c_d.tx_buffer_empty_flag = 1'b1;
        end
        if (wr_ctl) begin
            c_d.rx_full_irq_enable  = i_wdata[spi_irq_pkg::CTL_RIE_BIT];
            c_d.tx_empty_irq_enable = i_wdata[spi_irq_pkg::CTL_TIE_BIT];
            c_d.phase    = i_wdata[spi_irq_pkg::CTL_PHA_BIT];
            c_d.polarity = i_wdata[spi_irq_pkg::CTL_POL_BIT];
            c_d.master   = i_wdata[spi_irq_pkg::CTL_MS_BIT];
            c_d.enable   = i_wdata[spi_irq_pkg::CTL_EN_BIT];
        end
        // read data, unmapped reads zero
        c_d.rdata = 16'h0000;
        if (i_rd) begin
            if (hit(i_addr, spi_irq_pkg::ST_ADDR)) begin
                c_d.rdata = st_word;
            end else if (hit(i_addr, spi_irq_pkg::TXD_ADDR)) begin
                c_d.rdata = {8'h00, c_q.tx_buf};
            end else if (hit(i_addr, spi_irq_pkg::RXD_ADDR)) begin
                c_d.rdata = {8'h00, c_q.rx_buf};
            end else if (hit(i_addr, spi_irq_pkg::CTL_ADDR)) begin
                c_d.rdata = {10'h000, c_q.rx_full_irq_enable,
                             c_q.tx_empty_irq_enable, c_q.phase,
                             c_q.polarity, c_q.master, c_q.enable};
            end else if (hit(i_addr, spi_irq_pkg::IFLG_ADDR)) begin
                c_d.rdata[spi_irq_pkg::IRQ_CH_BIT] = ctrl_pending;
            end else if (hit(i_addr, spi_irq_pkg::IEN_ADDR)) begin
                c_d.rdata[spi_irq_pkg::IRQ_CH_BIT] = ctrl_fwd_en;
            end else if (hit(i_addr, spi_irq_pkg::ILV3_ADDR)) begin
                c_d.rdata[2:0] = ctrl_level;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            c_q.rx_full_irq_enable    <= spi_irq_pkg::BIT_RST;
            c_q.tx_empty_irq_enable   <= spi_irq_pkg::BIT_RST;
            c_q.phase                 <= spi_irq_pkg::BIT_RST;
            c_q.polarity              <= spi_irq_pkg::BIT_RST;
            c_q.master                <= spi_irq_pkg::BIT_RST;
            c_q.enable                <= spi_irq_pkg::BIT_RST;
            c_q.tx_buf                <= spi_irq_pkg::BYTE_RST;
            c_q.rx_buf                <= spi_irq_pkg::BYTE_RST;
            c_q.rx_buffer_full_flag   <= spi_irq_pkg::RXF_RST;
            c_q.tx_buffer_empty_flag  <= spi_irq_pkg::TXE_RST;
            c_q.busy_or_selected_flag <= spi_irq_pkg::BSY_RST;
            c_q.rdata                 <= 16'h0000;
        end else begin
            c_q <= c_d;
        end
    end

    // ========================================
    // interrupt controller slice
    chan_irq_slice u_irq_ctrl (
        .i_clk                    (i_clk),
        .i_rst                    (i_rst),
        .i_req_pulse              (o_irq_pulse),
        .i_flag_wr                (wr_iflg),
        .i_en_wr                  (wr_ien),
        .i_lvl_wr                 (wr_ilv),
        .i_wdata                  (i_wdata),
        .i_global_irq_allow_bit   (i_global_irq_allow_bit),
        .i_current_priority_field (i_current_priority_field),
        .i_higher_pending         (i_higher_pending),
        .o_pending                (ctrl_pending),
        .o_forward_enable         (ctrl_fwd_en),
        .o_level                  (ctrl_level),
        .o_core_req               (o_core_irq_req),
        .o_accept                 (o_irq_accept),
        .o_vector_num             (o_vector_num),
        .o_vector_offset          (o_vector_offset)
    );

    // ========================================
    // outputs
    assign o_rdata        = c_q.rdata;
    assign o_tx_byte      = c_q.tx_buf;
    assign o_chan_enable  = c_q.enable;
    assign o_master_mode  = c_q.master;
    assign o_clk_polarity = c_q.polarity;
    assign o_clk_phase    = c_q.phase;

    // ========================================
    // checks
    property p_rx_set;
        @(posedge i_clk) disable iff (i_rst)
        i_rx_load |=> c_q.rx_buffer_full_flag
                      && c_q.rx_buf == $past(i_rx_byte);
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("rx load did not set full flag");

    property p_rx_clr;
        @(posedge i_clk) disable iff (i_rst)
        rd_rx && !i_rx_load |=> !c_q.rx_buffer_full_flag;
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("rx read did not clear full flag");

    property p_tx_clr;
        @(posedge i_clk) disable iff (i_rst)
        wr_tx && !i_tx_load |=> !c_q.tx_buffer_empty_flag;
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("tx write did not clear empty flag");

    property p_tx_set;
        @(posedge i_clk) disable iff (i_rst)
        i_tx_load |=> c_q.tx_buffer_empty_flag;
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("tx load did not set empty flag");

    property p_rx_gate;
        @(posedge i_clk) disable iff (i_rst)
        i_rx_load && !c_q.rx_full_irq_enable && !tx_irq |-> !o_irq_pulse;
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("rx request while disabled");

    property p_pulse_cause;
        @(posedge i_clk) disable iff (i_rst)
        o_irq_pulse |-> (i_rx_load && c_q.rx_full_irq_enable)
                     || (i_tx_load && c_q.tx_empty_irq_enable);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("request pulse without enabled cause");

    property p_tx_irq;
        @(posedge i_clk) disable iff (i_rst)
        i_tx_load && c_q.tx_empty_irq_enable |-> o_irq_pulse;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("tx empty request missing");

    property p_slave_busy;
        @(posedge i_clk) disable iff (i_rst)
        !c_q.master |=> c_q.busy_or_selected_flag
                        == !$past(i_slave_select_in_n);
    endproperty
    a_slave_busy: assert property (p_slave_busy)
        else $error("slave busy does not mirror select");

    property p_master_busy;
        @(posedge i_clk) disable iff (i_rst)
        c_q.master && !wr_ctl && i_xfer_start |=>
            c_q.busy_or_selected_flag;
    endproperty
    a_master_busy: assert property (p_master_busy)
        else $error("master busy not set on start");

    property p_status_read;
        @(posedge i_clk) disable iff (i_rst)
        i_rd && hit(i_addr, spi_irq_pkg::ST_ADDR) |=>
            o_rdata[15:3] == 13'h0000
            && o_rdata[2:0] == $past(st_word[2:0]);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read value wrong");

    c_rx_irq: cover property (@(posedge i_clk) disable iff (i_rst)
        rx_irq);
    c_tx_irq: cover property (@(posedge i_clk) disable iff (i_rst)
        tx_irq);
    c_both: cover property (@(posedge i_clk) disable iff (i_rst)
        rx_irq && tx_irq);
    c_selected: cover property (@(posedge i_clk) disable iff (i_rst)
        !c_q.master && c_q.busy_or_selected_flag);
endmodule : spi_status_irq
`default_nettype wire

// >>> verilog/spi_irq_pkg.sv
// constants for the serial channel status and interrupt logic
`default_nettype none
package spi_irq_pkg;
    // ========================================
    // register addresses
    localparam logic [15:0] ST_ADDR   = 16'h4320;
    localparam logic [15:0] TXD_ADDR  = 16'h4322;
    localparam logic [15:0] RXD_ADDR  = 16'h4324;
    localparam logic [15:0] CTL_ADDR  = 16'h4326;
    localparam logic [15:0] IFLG_ADDR = 16'h4300;
    localparam logic [15:0] IEN_ADDR  = 16'h4302;
    localparam logic [15:0] ILV3_ADDR = 16'h4314;
    // ========================================
    // field positions
    localparam int ST_TXE_BIT  = 0;
    localparam int ST_RXF_BIT  = 1;
    localparam int ST_BSY_BIT  = 2;
    localparam int CTL_EN_BIT  = 0;
    localparam int CTL_MS_BIT  = 1;
    localparam int CTL_POL_BIT = 2;
    localparam int CTL_PHA_BIT = 3;
    localparam int CTL_TIE_BIT = 4;
    localparam int CTL_RIE_BIT = 5;
    localparam int IRQ_CH_BIT  = 14;
    localparam int LVL_LSB     = 0;
    localparam int LVL_W       = 3;
    // ========================================
    // reset values
    localparam logic       TXE_RST = 1'b1;
    localparam logic       RXF_RST = 1'b0;
    localparam logic       BSY_RST = 1'b0;
    localparam logic       BIT_RST = 1'b0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] LVL_RST = 3'h0;
    // ========================================
    // vector
    localparam logic [7:0] VEC_NUM = 8'h12;
    localparam logic [7:0] VEC_OFS = 8'h48;
endpackage : spi_irq_pkg
`default_nettype wire

// >>> verilog/chan_irq_slice.sv
// interrupt controller slice for the serial channel
`timescale 1ns/1ns
`default_nettype none
module chan_irq_slice (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_req_pulse,
    input  wire logic       i_flag_wr,
    input  wire logic       i_en_wr,
    input  wire logic       i_lvl_wr,
    input  wire logic [15:0] i_wdata,
    input  wire logic       i_global_irq_allow_bit,
    input  wire logic [2:0] i_current_priority_field,
    input  wire logic       i_higher_pending,
    output logic            o_pending,
    output logic            o_forward_enable,
    output logic [2:0]      o_level,
    output logic            o_core_req,
    output logic            o_accept,
    output logic [7:0]      o_vector_num,
    output logic [7:0]      o_vector_offset
);
    typedef struct packed {
        logic       pending;
        logic       fwd_en;
        logic [2:0] level;
    } slice_t;

    slice_t s_q;
    slice_t s_d;

    // ========================================
    // next state
    always_comb begin
        s_d = s_q;
        if (i_flag_wr && i_wdata[spi_irq_pkg::IRQ_CH_BIT]) begin
            s_d.pending = 1'b0;
        end
        if (i_req_pulse) begin
            s_d.pending = 1'b1;
        end
        if (i_en_wr) begin
            s_d.fwd_en = i_wdata[spi_irq_pkg::IRQ_CH_BIT];
        end
        if (i_lvl_wr) begin
            s_d.level = i_wdata[spi_irq_pkg::LVL_LSB +: spi_irq_pkg::LVL_W];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q.pending <= spi_irq_pkg::BIT_RST;
            s_q.fwd_en  <= spi_irq_pkg::BIT_RST;
            s_q.level   <= spi_irq_pkg::LVL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // outputs
    assign o_pending        = s_q.pending;
    assign o_forward_enable = s_q.fwd_en;
    assign o_level          = s_q.level;
    assign o_core_req = s_q.pending && s_q.fwd_en;
    assign o_accept = o_core_req && i_global_irq_allow_bit
                      && (s_q.level > i_current_priority_field)
                      && !i_higher_pending;
    assign o_vector_num    = spi_irq_pkg::VEC_NUM;
    assign o_vector_offset = spi_irq_pkg::VEC_OFS;

    // ========================================
    // checks
    property p_pend_set;
        @(posedge i_clk) disable iff (i_rst)
        i_req_pulse |=> s_q.pending;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("pending flag not set by pulse");

    property p_fwd_block;
        @(posedge i_clk) disable iff (i_rst)
        !s_q.fwd_en |-> !o_core_req;
    endproperty
    a_fwd_block: assert property (p_fwd_block)
        else $error("request forwarded while disabled");

    property p_accept;
        @(posedge i_clk) disable iff (i_rst)
        o_accept |-> (s_q.level > i_current_priority_field)
                     && i_global_irq_allow_bit && !i_higher_pending
                     && s_q.fwd_en;
    endproperty
    a_accept: assert property (p_accept)
        else $error("accept without all conditions");

    property p_level;
        @(posedge i_clk) disable iff (i_rst)
        i_lvl_wr |=> s_q.level == $past(i_wdata[2:0]);
    endproperty
    a_level: assert property (p_level)
        else $error("level field not written");

    c_accept: cover property (@(posedge i_clk) disable iff (i_rst)
        o_accept);
endmodule : chan_irq_slice
`default_nettype wire

// >>> verif/serial_datapath_model.sv
// behavioural model of the serial datapath feeding the status block
`timescale 1ns/1ns
`default_nettype none
module serial_datapath_model (
    input  wire logic  i_clk,
    output logic       o_rx_load,
    output logic [7:0] o_rx_byte,
    output logic       o_tx_load,
    output logic       o_xfer_start,
    output logic       o_xfer_done,
    output logic       o_slave_select_in_n
);
    // ========================================
    // idle levels
    initial begin
        o_rx_load           = 1'b0;
        o_rx_byte           = 8'h5a;
        o_tx_load           = 1'b0;
        o_xfer_start        = 1'b0;
        o_xfer_done         = 1'b0;
        o_slave_select_in_n = 1'b1;
    end
    // ========================================
    // events raised on one edge, held one cycle
    task automatic fire(input logic rx, input logic tx, input logic st,
                        input logic dn, input logic [7:0] b);
        @(posedge i_clk);
        o_rx_load    <= rx;
        o_rx_byte    <= b;
        o_tx_load    <= tx;
        o_xfer_start <= st;
        o_xfer_done  <= dn;
        #1;
    endtask : fire
    // events dropped, byte lines lose the value
    task automatic quiet;
        @(posedge i_clk);
        o_rx_load    <= 1'b0;
        o_rx_byte    <= ~o_rx_byte;
        o_tx_load    <= 1'b0;
        o_xfer_start <= 1'b0;
        o_xfer_done  <= 1'b0;
        #1;
    endtask : quiet
    task automatic select(input logic sel);
        @(posedge i_clk);
        o_slave_select_in_n <= ~sel;
    endtask : select
endmodule : serial_datapath_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the serial channel status and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk;
    logic        rst;
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rx_load;
    logic [7:0]  rx_byte;
    logic        tx_load;
    logic        xs;
    logic        xd;
    logic        ss_n;
    logic        allow;
    logic [2:0]  cur;
    logic        higher;
    logic [7:0]  tx_byte;
    logic [3:0]  ctl;
    logic        pulse;
    logic        core_req;
    logic        accept;
    logic [7:0]  vnum;
    logic [7:0]  vofs;
    int          bad_count;
    int          check_count;
    // ========================================
    // design and datapath model
    spi_status_irq DUT (
        .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .i_rx_load(rx_load),
        .i_rx_byte(rx_byte), .i_tx_load(tx_load), .i_xfer_start(xs),
        .i_xfer_done(xd), .i_slave_select_in_n(ss_n),
        .i_global_irq_allow_bit(allow), .i_current_priority_field(cur),
        .i_higher_pending(higher), .o_tx_byte(tx_byte),
        .o_chan_enable(ctl[0]), .o_master_mode(ctl[1]),
        .o_clk_polarity(ctl[2]), .o_clk_phase(ctl[3]),
        .o_irq_pulse(pulse), .o_core_irq_req(core_req),
        .o_irq_accept(accept), .o_vector_num(vnum), .o_vector_offset(vofs)
    );
    serial_datapath_model peer (
        .i_clk(clk), .o_rx_load(rx_load), .o_rx_byte(rx_byte),
        .o_tx_load(tx_load), .o_xfer_start(xs), .o_xfer_done(xd),
        .o_slave_select_in_n(ss_n)
    );
    // ========================================
    // clock, reset, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        bad_count = bad_count + 1;
        close_out();
    end
    // ========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
        #1;
    endtask : reg_wr
    task automatic expect_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : expect_rd
    task automatic core(input logic al, input logic [2:0] c,
                        input logic hi, input logic exp);
        @(posedge clk);
        allow  <= al;
        cur    <= c;
        higher <= hi;
        #1;
        check(16'(accept), 16'(exp));
    endtask : core
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // ========================================
    // scenarios
    task automatic t_reset;
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0001);
        expect_rd(spi_irq_pkg::CTL_ADDR, 16'h0000);
        expect_rd(spi_irq_pkg::TXD_ADDR, 16'h0000);
        expect_rd(spi_irq_pkg::RXD_ADDR, 16'h0000);
        expect_rd(spi_irq_pkg::IEN_ADDR, 16'h0000);
        expect_rd(spi_irq_pkg::ILV3_ADDR, 16'h0000);
        expect_rd(16'h4328, 16'h0000);
        check(16'(vnum), 16'h0012);
        check(16'(vofs), 16'h0048);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx;
        peer.fire(1'b1, 1'b0, 1'b0, 1'b0, 8'h3c);
        check(16'(pulse), 16'h0000);
        peer.quiet();
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        reg_wr(spi_irq_pkg::CTL_ADDR, 16'h0020);
        peer.fire(1'b1, 1'b0, 1'b0, 1'b0, 8'hc3);
        check(16'(pulse), 16'h0001);
        peer.quiet();
        check(16'(pulse), 16'h0000);
        expect_rd(spi_irq_pkg::IFLG_ADDR, 16'h4000);
        check(16'(core_req), 16'h0000);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        expect_rd(spi_irq_pkg::RXD_ADDR, 16'h00c3);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0001);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx;
        reg_wr(spi_irq_pkg::TXD_ADDR, 16'h00a5);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0000);
        check(16'(tx_byte), 16'h00a5);
        peer.fire(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        check(16'(pulse), 16'h0000);
        peer.quiet();
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0001);
        reg_wr(spi_irq_pkg::CTL_ADDR, 16'h0030);
        reg_wr(spi_irq_pkg::TXD_ADDR, 16'h005a);
        peer.fire(1'b1, 1'b1, 1'b0, 1'b0, 8'h77);
        check(16'(pulse), 16'h0001);
        peer.quiet();
        check(16'(pulse), 16'h0000);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        expect_rd(spi_irq_pkg::CTL_ADDR, 16'h0030);
        $display("test tx done");
    endtask : t_tx
    task automatic t_irq_ctrl;
        reg_wr(spi_irq_pkg::IEN_ADDR, 16'h4000);
        expect_rd(spi_irq_pkg::IEN_ADDR, 16'h4000);
        check(16'(core_req), 16'h0001);
        reg_wr(spi_irq_pkg::ILV3_ADDR, 16'h0005);
        expect_rd(spi_irq_pkg::ILV3_ADDR, 16'h0005);
        core(1'b1, 3'h4, 1'b0, 1'b1);
        core(1'b1, 3'h5, 1'b0, 1'b0);
        core(1'b0, 3'h4, 1'b0, 1'b0);
        core(1'b1, 3'h4, 1'b1, 1'b0);
        reg_wr(spi_irq_pkg::IEN_ADDR, 16'h0000);
        check(16'(core_req), 16'h0000);
        core(1'b1, 3'h0, 1'b0, 1'b0);
        reg_wr(spi_irq_pkg::IFLG_ADDR, 16'h4000);
        expect_rd(spi_irq_pkg::IFLG_ADDR, 16'h0000);
        reg_wr(spi_irq_pkg::ILV3_ADDR, 16'h0007);
        expect_rd(spi_irq_pkg::ILV3_ADDR, 16'h0007);
        $display("test controller done");
    endtask : t_irq_ctrl
    task automatic t_busy;
        reg_wr(spi_irq_pkg::CTL_ADDR, 16'h0003);
        check(16'(ctl), 16'h0003);
        peer.fire(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        peer.quiet();
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0007);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0007);
        peer.fire(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        peer.quiet();
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        reg_wr(spi_irq_pkg::CTL_ADDR, 16'h000d);
        check(16'(ctl), 16'h000d);
        peer.select(1'b1);
        repeat (2) @(posedge clk);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0007);
        peer.select(1'b0);
        repeat (2) @(posedge clk);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        reg_wr(spi_irq_pkg::ST_ADDR, 16'h0006);
        reg_wr(spi_irq_pkg::RXD_ADDR, 16'h00ff);
        expect_rd(spi_irq_pkg::ST_ADDR, 16'h0003);
        expect_rd(spi_irq_pkg::RXD_ADDR, 16'h0077);
        $display("test busy done");
    endtask : t_busy
    // ========================================
    // main sequence
    initial begin
        bad_count   = 0;
        check_count = 0;
        rst         = 1'b1;
        addr        = 16'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        wdata       = 16'h0000;
        allow       = 1'b0;
        cur         = 3'h0;
        higher      = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_rx();
        t_tx();
        t_irq_ctrl();
        t_busy();
        close_out();
    end
endmodule : testbench
`default_nettype wire
